// file: logic/bdms_cfg.svh
// constants of the banked data memory and its arithmetic/reset status register
`ifndef BDMS_CFG_SVH
`define BDMS_CFG_SVH

// ==================================================
// memory geometry
`define BDMS_NUM_BANKS 32
`define BDMS_BANK_BYTES 128
`define BDMS_GP_PER_BANK 80
`define BDMS_GP_TOTAL 2560
`define BDMS_COMMON_BYTES 16
`define BDMS_CORE_LAST 7'h0B
`define BDMS_PERIPH_FIRST 7'h0C
`define BDMS_PERIPH_LAST 7'h1F
`define BDMS_GP_FIRST 7'h20
`define BDMS_GP_LAST 7'h6F
`define BDMS_COMMON_FIRST 7'h70
`define BDMS_NOPERIPH_BANK_LO 5'h1B
`define BDMS_NOPERIPH_BANK_HI 5'h1D
`define BDMS_LINEAR_TAG 3'h1
`define BDMS_TRAD_TAG 4'h0

// ==================================================
// core register offsets
`define BDMS_OFF_INDIRECT_ACCESS_0 4'h0
`define BDMS_OFF_INDIRECT_ACCESS_1 4'h1
`define BDMS_OFF_PROGRAM_COUNTER_LOW_BYTE 4'h2
`define BDMS_OFF_ALU_AND_RESET_FLAGS 4'h3
`define BDMS_OFF_POINTER0_LOW 4'h4
`define BDMS_OFF_POINTER0_HIGH 4'h5
`define BDMS_OFF_POINTER1_LOW 4'h6
`define BDMS_OFF_POINTER1_HIGH 4'h7
`define BDMS_OFF_BANK_SELECTOR 4'h8
`define BDMS_OFF_WORKING_ACCUMULATOR 4'h9
`define BDMS_OFF_PROGRAM_COUNTER_HIGH_LATCH 4'hA
`define BDMS_OFF_INTERRUPT_CONTROL 4'hB

// ==================================================
// status field positions
`define BDMS_ST_TIMEOUT 4
`define BDMS_ST_POWERDOWN 3
`define BDMS_ST_ZERO 2
`define BDMS_ST_DIGIT 1
`define BDMS_ST_CARRY 0

// ==================================================
// reset values and interrupt control write mask
`define BDMS_RST_STATUS 5'h18
`define BDMS_RST_INTCTL 8'h01
`define BDMS_INTCTL_MASK 8'hC1

`endif

// file: logic/bdms_pkg.sv
// types of the banked data memory and status register block
package bdms_pkg;

    typedef enum logic [2:0] {
        BDMS_OP_MOVE,
        BDMS_OP_ADD,
        BDMS_OP_SUB,
        BDMS_OP_LOGIC,
        BDMS_OP_ROTR,
        BDMS_OP_ROTL,
        BDMS_OP_CLEAR
    } bdms_op_e;

    typedef enum logic [2:0] {
        BDMS_RG_NONE,
        BDMS_RG_CORE,
        BDMS_RG_PERIPH,
        BDMS_RG_GP,
        BDMS_RG_COMMON
    } bdms_region_e;

    typedef struct packed {
        bdms_region_e region;
        logic [11:0] idx;
        logic [11:0] addr;
    } bdms_target_s;

    typedef struct packed {
        logic [4:0] bank_selector;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0] w;
        logic [7:0] program_counter_low_byte;
        logic [6:0] program_counter_high_latch;
        logic [7:0] intctl;
        logic [4:0] status;
        logic [7:0] rd_data;
        logic rd_valid;
    } bdms_state_s;

endpackage : bdms_pkg

// file: logic/bdms_core.sv
// banked data memory with core registers, common RAM and the alu/reset status register
`timescale 1ns/100ps
`include "bdms_cfg.svh"

module bdms_core
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [6:0] file_addr_i,
    input wire logic rd_en_i,
    input wire logic exec_i,
    input wire bdms_pkg::bdms_op_e op_i,
    input wire logic dest_file_i,
    input wire logic [7:0] opnd_a_i,
    input wire logic [7:0] opnd_b_i,
    input wire logic clear_watchdog_instruction_i,
    input wire logic sleep_i,
    input wire logic wdt_timeout_i,
    input wire logic [7:0] periph_rdata_i,
    output logic periph_rd_o,
    output logic periph_wr_o,
    output logic [11:0] periph_addr_o,
    output logic [7:0] periph_wdata_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic [7:0] status_o,
    output logic [4:0] bank_o,
    output logic [7:0] w_o,
    output logic [7:0] pcl_o,
    output logic [6:0] program_counter_high_latch_o,
    output logic [7:0] intctl_o,
    output logic [15:0] ptr0_o,
    output logic [15:0] ptr1_o
);
    import bdms_pkg::*;

    // ==================================================
    // state and memories
    bdms_state_s state_reg;
    bdms_state_s state_next;
    // ram arrays carry no reset; contents are unknown after power-up
    logic [7:0] gp_ram [0:`BDMS_GP_TOTAL-1];
    logic [7:0] common_ram [0:`BDMS_COMMON_BYTES-1];

    logic [15:0] src_addr;
    bdms_target_s tgt;
    logic [7:0] core_rd;
    logic [7:0] rd_byte;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] addend;
    logic cin;
    logic [7:0] result;
    logic z_new;
    logic dc_new;
    logic c_new;
    logic aff_z;
    logic aff_dc;
    logic aff_c;
    logic wr_any;
    logic gp_we;
    logic common_we;

    // ==================================================
    // address resolution
    function automatic bdms_target_s resolve(input logic [15:0] a);
        bdms_target_s t;
        logic [4:0] bank;
        logic [6:0] off;
        t = '{region: BDMS_RG_NONE, idx: 12'h000, addr: a[11:0]};
        bank = a[11:7];
        off = a[6:0];
        if (a[15:13] == `BDMS_LINEAR_TAG)
        begin
            // linear window: consecutive gp ram bytes, bank after bank
            if (a[12:0] < 13'(`BDMS_GP_TOTAL))
            begin
                t.region = BDMS_RG_GP;
                t.idx = a[11:0];
                t.addr = 12'({5'(a[11:0] / 12'(`BDMS_GP_PER_BANK)), 7'h00})
                    | 12'(7'(a[11:0] % 12'(`BDMS_GP_PER_BANK)) + `BDMS_GP_FIRST);
            end
        end
        else if (a[15:12] == `BDMS_TRAD_TAG)
        begin
            if (off <= `BDMS_CORE_LAST)
            begin
                t.region = BDMS_RG_CORE;
                t.idx = {8'h00, off[3:0]};
            end
            else if (off <= `BDMS_PERIPH_LAST)
            begin
                if (bank < `BDMS_NOPERIPH_BANK_LO || bank > `BDMS_NOPERIPH_BANK_HI)
                    t.region = BDMS_RG_PERIPH;
            end
            else if (off <= `BDMS_GP_LAST)
            begin
                t.region = BDMS_RG_GP;
                t.idx = 12'(bank * 12'(`BDMS_GP_PER_BANK)) + 12'(off - `BDMS_GP_FIRST);
            end
            else
            begin
                t.region = BDMS_RG_COMMON;
                t.idx = {8'h00, off[3:0]};
            end
        end
        return t;
    endfunction : resolve

    // the indirect access offsets redirect through the matching pointer
    always_comb
    begin
        if (file_addr_i == 7'({3'h0, `BDMS_OFF_INDIRECT_ACCESS_0}))
            src_addr = state_reg.ptr0;
        else if (file_addr_i == 7'({3'h0, `BDMS_OFF_INDIRECT_ACCESS_1}))
            src_addr = state_reg.ptr1;
        else
            src_addr = {4'h0, state_reg.bank_selector, file_addr_i};
    end

    assign tgt = resolve(src_addr);

    // ==================================================
    // read path
    always_comb
    begin
        case (tgt.idx[3:0])
            `BDMS_OFF_PROGRAM_COUNTER_LOW_BYTE: core_rd = state_reg.program_counter_low_byte;
            `BDMS_OFF_ALU_AND_RESET_FLAGS: core_rd = {3'h0, state_reg.status};
            `BDMS_OFF_POINTER0_LOW: core_rd = state_reg.ptr0[7:0];
            `BDMS_OFF_POINTER0_HIGH: core_rd = state_reg.ptr0[15:8];
            `BDMS_OFF_POINTER1_LOW: core_rd = state_reg.ptr1[7:0];
            `BDMS_OFF_POINTER1_HIGH: core_rd = state_reg.ptr1[15:8];
            `BDMS_OFF_BANK_SELECTOR: core_rd = {3'h0, state_reg.bank_selector};
            `BDMS_OFF_WORKING_ACCUMULATOR: core_rd = state_reg.w;
            `BDMS_OFF_PROGRAM_COUNTER_HIGH_LATCH: core_rd = {1'b0, state_reg.program_counter_high_latch};
            `BDMS_OFF_INTERRUPT_CONTROL: core_rd = state_reg.intctl;
            // a pointer aimed at an access port is no physical register
            default: core_rd = 8'h00;
        endcase
    end

    always_comb
    begin
        case (tgt.region)
            BDMS_RG_CORE: rd_byte = core_rd;
            BDMS_RG_PERIPH: rd_byte = periph_rdata_i;
            BDMS_RG_GP: rd_byte = gp_ram[tgt.idx];
            BDMS_RG_COMMON: rd_byte = common_ram[tgt.idx[3:0]];
            default: rd_byte = 8'h00;
        endcase
    end

    // ==================================================
    // alu flags
    always_comb
    begin
        // subtraction is addition of the two's complement of the second operand
        addend = (op_i == BDMS_OP_SUB) ? ~opnd_b_i : opnd_b_i;
        cin = (op_i == BDMS_OP_SUB);
        sum9 = {1'b0, opnd_a_i} + {1'b0, addend} + {8'h00, cin};
        sum5 = {1'b0, opnd_a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        aff_z = 1'b0;
        aff_dc = 1'b0;
        aff_c = 1'b0;
        z_new = 1'b0;
        dc_new = sum5[4];
        c_new = sum9[8];
        case (op_i)
            BDMS_OP_ADD, BDMS_OP_SUB:
            begin
                result = sum9[7:0];
                aff_z = 1'b1;
                aff_dc = 1'b1;
                aff_c = 1'b1;
            end
            BDMS_OP_LOGIC:
            begin
                result = opnd_a_i;
                aff_z = 1'b1;
            end
            BDMS_OP_ROTR:
            begin
                result = {state_reg.status[`BDMS_ST_CARRY], opnd_a_i[7:1]};
                c_new = opnd_a_i[0];
                aff_c = 1'b1;
            end
            BDMS_OP_ROTL:
            begin
                result = {opnd_a_i[6:0], state_reg.status[`BDMS_ST_CARRY]};
                c_new = opnd_a_i[7];
                aff_c = 1'b1;
            end
            BDMS_OP_CLEAR:
            begin
                result = 8'h00;
                aff_z = 1'b1;
            end
            default: result = opnd_a_i;
        endcase
        z_new = (result == 8'h00);
    end

    // ==================================================
    // next state
    always_comb
    begin
        state_next = state_reg;
        state_next.rd_valid = 1'b0;
        if (rd_en_i)
        begin
            state_next.rd_data = rd_byte;
            state_next.rd_valid = 1'b1;
        end
        if (exec_i)
        begin
            if (aff_z)
                state_next.status[`BDMS_ST_ZERO] = z_new;
            if (aff_dc)
                state_next.status[`BDMS_ST_DIGIT] = dc_new;
            if (aff_c)
                state_next.status[`BDMS_ST_CARRY] = c_new;
            if (!dest_file_i)
                state_next.w = result;
            else if (tgt.region == BDMS_RG_CORE)
            begin
                case (tgt.idx[3:0])
                    `BDMS_OFF_PROGRAM_COUNTER_LOW_BYTE: state_next.program_counter_low_byte = result;
                    `BDMS_OFF_ALU_AND_RESET_FLAGS:
                    begin
                        // time-out/power-down are never written; flags win over data
                        if (!(aff_z || aff_dc || aff_c))
                            state_next.status[2:0] = result[2:0];
                    end
                    `BDMS_OFF_POINTER0_LOW: state_next.ptr0[7:0] = result;
                    `BDMS_OFF_POINTER0_HIGH: state_next.ptr0[15:8] = result;
                    `BDMS_OFF_POINTER1_LOW: state_next.ptr1[7:0] = result;
                    `BDMS_OFF_POINTER1_HIGH: state_next.ptr1[15:8] = result;
                    `BDMS_OFF_BANK_SELECTOR: state_next.bank_selector = result[4:0];
                    `BDMS_OFF_WORKING_ACCUMULATOR: state_next.w = result;
                    `BDMS_OFF_PROGRAM_COUNTER_HIGH_LATCH: state_next.program_counter_high_latch = result[6:0];
                    `BDMS_OFF_INTERRUPT_CONTROL: state_next.intctl = result & `BDMS_INTCTL_MASK;
                    default: state_next.program_counter_low_byte = state_reg.program_counter_low_byte;
                endcase
            end
        end
        // hardware events; a time-out in the same cycle as clear-watchdog wins
        if (clear_watchdog_instruction_i)
        begin
            state_next.status[`BDMS_ST_TIMEOUT] = 1'b1;
            state_next.status[`BDMS_ST_POWERDOWN] = 1'b1;
        end
        if (sleep_i)
        begin
            state_next.status[`BDMS_ST_TIMEOUT] = 1'b1;
            state_next.status[`BDMS_ST_POWERDOWN] = 1'b0;
        end
        if (wdt_timeout_i)
            state_next.status[`BDMS_ST_TIMEOUT] = 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= '0;
            state_reg.status <= `BDMS_RST_STATUS;
            state_reg.intctl <= `BDMS_RST_INTCTL;
        end
        else
            state_reg <= state_next;
    end

    // ==================================================
    // ram writes
    assign wr_any = exec_i && dest_file_i;
    assign gp_we = wr_any && (tgt.region == BDMS_RG_GP);
    assign common_we = wr_any && (tgt.region == BDMS_RG_COMMON);

    always_ff @(posedge ref_clk_i)
    begin
        if (gp_we)
            gp_ram[tgt.idx] <= result;
        if (common_we)
            common_ram[tgt.idx[3:0]] <= result;
    end

    // ==================================================
    // outputs
    assign periph_rd_o = rd_en_i && (tgt.region == BDMS_RG_PERIPH);
    assign periph_wr_o = wr_any && (tgt.region == BDMS_RG_PERIPH);
    assign periph_addr_o = tgt.addr;
    assign periph_wdata_o = result;
    assign rd_data_o = state_reg.rd_data;
    assign rd_valid_o = state_reg.rd_valid;
    assign status_o = {3'h0, state_reg.status};
    assign bank_o = state_reg.bank_selector;
    assign w_o = state_reg.w;
    assign pcl_o = state_reg.program_counter_low_byte;
    assign program_counter_high_latch_o = state_reg.program_counter_high_latch;
    assign intctl_o = state_reg.intctl;
    assign ptr0_o = state_reg.ptr0;
    assign ptr1_o = state_reg.ptr1;

    // ==================================================
    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic to_status;
    logic no_evt;
    assign to_status = exec_i && dest_file_i && (tgt.region == BDMS_RG_CORE)
        && (tgt.idx[3:0] == `BDMS_OFF_ALU_AND_RESET_FLAGS);
    assign no_evt = !clear_watchdog_instruction_i && !sleep_i && !wdt_timeout_i;

    chk_upper_bits_zero: assert property (status_o[7:5] == 3'h0)
        else $error("status upper bits not zero");
    chk_reset_flags_locked: assert property (to_status && no_evt |=> $stable(status_o[4:3]))
        else $error("time-out or power-down flag written");
    chk_clear_status_pattern: assert property (to_status && op_i == BDMS_OP_CLEAR && no_evt
        |=> status_o == {3'h0, $past(status_o[4:3]), 1'b1, $past(status_o[1:0])})
        else $error("clear of status gave wrong pattern");
    chk_add_flags_kept: assert property (to_status && op_i == BDMS_OP_ADD
        |=> status_o[1:0] == {$past(sum5[4]), $past(sum9[8])})
        else $error("add into status lost logic flags");
    chk_timeout_clears: assert property (wdt_timeout_i |=> !status_o[4] ##1 !status_o[4] || $past(clear_watchdog_instruction_i || sleep_i))
        else $error("time-out flag not cleared");
    chk_sleep_flags: assert property (sleep_i && !wdt_timeout_i |=> status_o[4:3] == 2'b10)
        else $error("sleep flags wrong");
    chk_zero_flag: assert property (exec_i && !to_status && op_i inside {BDMS_OP_ADD, BDMS_OP_LOGIC}
        |=> status_o[2] == ($past(result) == 8'h00))
        else $error("zero flag wrong");
    chk_borrow_polarity: assert property (exec_i && !to_status && op_i == BDMS_OP_SUB
        |=> status_o[0] == ($past(opnd_a_i) >= $past(opnd_b_i)))
        else $error("subtract carry is not inverted borrow");
    chk_rotate_carry: assert property (exec_i && !to_status && op_i == BDMS_OP_ROTR
        |=> status_o[0] == $past(opnd_a_i[0]))
        else $error("rotate right carry wrong");
    chk_unmapped_zero: assert property (rd_en_i && tgt.region == BDMS_RG_NONE
        |=> rd_valid_o && rd_data_o == 8'h00)
        else $error("unimplemented location read not zero");
    chk_core_shared: assert property (rd_en_i && file_addr_i == 7'h08
        |=> rd_data_o == {3'h0, $past(bank_o)})
        else $error("core register differs by bank");

    cov_linear_write: cover property (gp_we && src_addr[15:13] == `BDMS_LINEAR_TAG);
    cov_common_read: cover property (rd_en_i && tgt.region == BDMS_RG_COMMON && bank_o != 5'h00);
    cov_status_clear: cover property (to_status && op_i == BDMS_OP_CLEAR);
    cov_sleep_then_wake: cover property (sleep_i ##[1:20] clear_watchdog_instruction_i);

endmodule : bdms_core

// file: sim/bdms_cpu_model.sv
// cpu-side datapath model driving the read/execute ports plus a peripheral register stub
`timescale 1ns/100ps

module bdms_cpu_model
(
    input wire logic ref_clk_i,
    input wire logic periph_rd_i,
    input wire logic periph_wr_i,
    input wire logic [11:0] periph_addr_i,
    input wire logic [7:0] periph_wdata_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i,
    output logic [6:0] file_addr_o,
    output logic rd_en_o,
    output logic exec_o,
    output bdms_pkg::bdms_op_e op_o,
    output logic dest_file_o,
    output logic [7:0] opnd_a_o,
    output logic [7:0] opnd_b_o,
    output logic clear_watchdog_instruction_o,
    output logic sleep_o,
    output logic wdt_timeout_o,
    output logic [7:0] periph_rdata_o
);
    import bdms_pkg::*;

    logic [7:0] preg [0:31];
    logic [7:0] noise = 8'h5A;
    logic seen_prd;
    logic seen_pwr;
    logic [11:0] seen_paddr;

    initial
    begin
        file_addr_o = 7'h00;
        rd_en_o = 1'b0;
        exec_o = 1'b0;
        op_o = BDMS_OP_MOVE;
        dest_file_o = 1'b0;
        opnd_a_o = 8'h00;
        opnd_b_o = 8'h00;
        clear_watchdog_instruction_o = 1'b0;
        sleep_o = 1'b0;
        wdt_timeout_o = 1'b0;
        for (int i = 0; i < 32; i++)
            preg[i] = 8'h00;
    end

    // ==========================================
    // peripheral stub: an unselected bus shows a moving pattern, never the last value
    always @(posedge ref_clk_i)
    begin
        noise <= ~noise;
        if (periph_wr_i)
            preg[periph_addr_i[4:0]] <= periph_wdata_i;
    end

    assign periph_rdata_o = periph_rd_i ? preg[periph_addr_i[4:0]] : noise;

    // ==========================================
    // access tasks: drive after the falling edge, hold across the taking edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        file_addr_o = a;
        rd_en_o = 1'b1;
        #1 seen_prd = periph_rd_i;
        seen_paddr = periph_addr_i;
        @(negedge ref_clk_i);
        rd_en_o = 1'b0;
        d = rd_valid_i ? rd_data_i : 8'hxx;
    endtask : rd

    task automatic ex(input bdms_op_e op, input logic dst, input logic [6:0] a, input logic [7:0] x,
                      input logic [7:0] y);
        @(negedge ref_clk_i);
        op_o = op;
        dest_file_o = dst;
        file_addr_o = a;
        opnd_a_o = x;
        opnd_b_o = y;
        exec_o = 1'b1;
        #1 seen_pwr = periph_wr_i;
        seen_paddr = periph_addr_i;
        @(negedge ref_clk_i);
        exec_o = 1'b0;
    endtask : ex

    // m = {clear watchdog, sleep, watchdog time-out}
    task automatic ev(input logic [2:0] m);
        @(negedge ref_clk_i);
        {clear_watchdog_instruction_o, sleep_o, wdt_timeout_o} = m;
        @(negedge ref_clk_i);
        {clear_watchdog_instruction_o, sleep_o, wdt_timeout_o} = 3'b000;
    endtask : ev
endmodule : bdms_cpu_model

// file: sim/banked_data_memory_status_bench.sv
// self-checking bench for the banked data memory and status register
`timescale 1ns/100ps

module banked_data_memory_status_bench;
    import bdms_pkg::*;

    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [6:0] file_addr;
    logic rd_en;
    logic exec;
    bdms_op_e op;
    logic dest_file;
    logic [7:0] opa;
    logic [7:0] opb;
    logic clear_watchdog_instruction;
    logic sleep;
    logic wdt;
    logic [7:0] prdata;
    logic prd;
    logic pwr;
    logic [11:0] paddr;
    logic [7:0] pwdata;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [7:0] status_o;
    logic [4:0] bank_o;
    logic [7:0] w_o;
    logic [7:0] program_counter_low_byte;
    logic [6:0] program_counter_high_latch;
    logic [7:0] intctl_o;
    logic [15:0] ptr0_o;
    logic [15:0] ptr1;
    logic [7:0] d;
    int miscompares = 0;
    int num_checks = 0;

    always #25 ref_clk_i = ~ref_clk_i;

    bdms_core bdms_core_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .file_addr_i(file_addr),
        .rd_en_i(rd_en), .exec_i(exec), .op_i(op), .dest_file_i(dest_file), .opnd_a_i(opa),
        .opnd_b_i(opb), .clear_watchdog_instruction_i(clear_watchdog_instruction), .sleep_i(sleep), .wdt_timeout_i(wdt),
        .periph_rdata_i(prdata), .periph_rd_o(prd), .periph_wr_o(pwr), .periph_addr_o(paddr),
        .periph_wdata_o(pwdata), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .status_o(status_o),
        .bank_o(bank_o), .w_o(w_o), .pcl_o(program_counter_low_byte), .program_counter_high_latch_o(program_counter_high_latch), .intctl_o(intctl_o),
        .ptr0_o(ptr0_o), .ptr1_o(ptr1));

    bdms_cpu_model bdms_cpu_model_inst (.ref_clk_i(ref_clk_i), .periph_rd_i(prd), .periph_wr_i(pwr),
        .periph_addr_i(paddr), .periph_wdata_i(pwdata), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .file_addr_o(file_addr), .rd_en_o(rd_en), .exec_o(exec), .op_o(op), .dest_file_o(dest_file),
        .opnd_a_o(opa), .opnd_b_o(opb), .clear_watchdog_instruction_o(clear_watchdog_instruction), .sleep_o(sleep), .wdt_timeout_o(wdt),
        .periph_rdata_o(prdata));

    // ==========================================
    // helpers
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // a plain move leaves the flags alone, the safe way to change status
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        bdms_cpu_model_inst.ex(BDMS_OP_MOVE, 1'b1, a, v, 8'h00);
    endtask : wr

    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        bdms_cpu_model_inst.rd(a, d);
        chk(d, e);
    endtask : rdc

    task automatic alu(input bdms_op_e o, input logic [7:0] a, input logic [7:0] b, input logic [7:0] ew,
                       input logic [7:0] es);
        bdms_cpu_model_inst.ex(o, 1'b0, 7'h00, a, b);
        chk(w_o, ew);
        chk(status_o, es);
    endtask : alu

    task automatic final_report;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // ==========================================
    // watchdog: the sequence needs about 130 cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        miscompares++;
        final_report();
    end

    // ==========================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        chk(status_o, 8'h18);
        chk(status_o[3], 1'b1);
        chk(intctl_o, 8'h01);
        rdc(7'h03, 8'h18);
        wr(7'h08, 8'hFF);
        chk(bank_o, 5'h1F);
        wr(7'h72, 8'hA5);
        wr(7'h09, 8'h3C);
        wr(7'h08, 8'h00);
        rdc(7'h72, 8'hA5);
        rdc(7'h09, 8'h3C);
        chk(w_o, 8'h3C);
        wr(7'h0C, 8'hC3);
        chk(bdms_cpu_model_inst.seen_pwr, 1'b1);
        // banks 27..29 have no peripheral window, their neighbours do
        for (int b = 26; b <= 30; b++)
        begin
            wr(7'h08, b[7:0]);
            bdms_cpu_model_inst.rd(7'h0C, d);
            chk(bdms_cpu_model_inst.seen_prd, (b < 27 || b > 29));
            chk(bdms_cpu_model_inst.seen_paddr, {b[4:0], 7'h0C});
            chk(d, (b < 27 || b > 29) ? 8'hC3 : 8'h00);
        end
        wr(7'h08, 8'h02);
        wr(7'h20, 8'h5A);
        wr(7'h04, 8'hA0);
        wr(7'h05, 8'h20);
        chk(ptr0_o, 16'h20A0);
        rdc(7'h00, 8'h5A);
        wr(7'h06, 8'hFF);
        wr(7'h07, 8'h29);
        wr(7'h01, 8'h77);
        wr(7'h08, 8'h1F);
        rdc(7'h6F, 8'h77);
        wr(7'h06, 8'h00);
        wr(7'h07, 8'h2A);
        rdc(7'h01, 8'h00);
        wr(7'h06, 8'h72);
        wr(7'h07, 8'h00);
        rdc(7'h01, 8'hA5);
        chk(ptr1, 16'h0072);
        // remaining core registers, reached from bank 31
        wr(7'h02, 8'h5A);
        chk(program_counter_low_byte, 8'h5A);
        wr(7'h0A, 8'hFF);
        chk(program_counter_high_latch, 7'h7F);
        rdc(7'h0A, 8'h7F);
        wr(7'h0B, 8'hFF);
        chk(intctl_o, 8'hC1);
        // flag arithmetic, status starts at 18h
        alu(BDMS_OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h1A);
        alu(BDMS_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h1F);
        alu(BDMS_OP_SUB, 8'h05, 8'h06, 8'hFF, 8'h18);
        alu(BDMS_OP_SUB, 8'h06, 8'h06, 8'h00, 8'h1F);
        alu(BDMS_OP_LOGIC, 8'h01, 8'h00, 8'h01, 8'h1B);
        // rotates go through carry: right rotate takes carry in 1, bit 0 out is 0; left takes carry in 0, bit 7 out is 1
        alu(BDMS_OP_ROTR, 8'h02, 8'h00, 8'h81, 8'h1A);
        alu(BDMS_OP_ROTL, 8'h80, 8'h00, 8'h00, 8'h1B);
        alu(BDMS_OP_LOGIC, 8'h00, 8'h00, 8'h00, 8'h1F);
        alu(BDMS_OP_MOVE, 8'h00, 8'h00, 8'h00, 8'h1F);
        // status as destination
        wr(7'h03, 8'hFF);
        chk(status_o, 8'h1F);
        wr(7'h03, 8'h00);
        chk(status_o, 8'h18);
        bdms_cpu_model_inst.ex(BDMS_OP_ADD, 1'b1, 7'h03, 8'hFF, 8'h01);
        chk(status_o, 8'h1F);
        wr(7'h03, 8'h01);
        bdms_cpu_model_inst.ex(BDMS_OP_CLEAR, 1'b1, 7'h03, 8'h00, 8'h00);
        chk(status_o, 8'h1D);
        rdc(7'h03, 8'h1D);
        // reset-status events
        bdms_cpu_model_inst.ev(3'b010);
        chk(status_o[4:3], 2'b10);
        bdms_cpu_model_inst.ev(3'b001);
        chk(status_o[4:3], 2'b00);
        bdms_cpu_model_inst.ev(3'b100);
        chk(status_o[4:3], 2'b11);
        bdms_cpu_model_inst.ev(3'b101);
        chk(status_o[4:3], 2'b01);
        // second power-up in mid-run must set both reset flags again
        @(negedge ref_clk_i);
        rst_b_i = 1'b0;
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        chk(status_o, 8'h18);
        chk(bank_o, 5'h00);
        rdc(7'h03, 8'h18);
        final_report();
    end
endmodule : banked_data_memory_status_bench
